// [logic/tpcf_pkg.sv]
// shared constants and carrier types of the phase compensation fifo ports
package tpcf_pkg;

    // ************************************************************
    // data path geometry
    // ************************************************************
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int ADDR_W = 2;
    localparam int PTR_W = 3;
    localparam logic [PTR_W-1:0] FIFO_FULL_LEVEL = 3'h4;
    localparam logic [PTR_W-1:0] FIFO_PRIME_LEVEL = 3'h2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int PAR_CLK_HZ = 2_500_000;
    localparam int PAR_HALF_CYCLES = SYS_CLK_HZ / (2 * PAR_CLK_HZ);
    localparam logic [1:0] PAR_HALF_LAST = 2'(PAR_HALF_CYCLES - 1);
    localparam logic [1:0] RST_PIPE_RESET = 2'h0;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic rxDigitalReset;
        logic txDigitalReset;
        logic powerDown;
        logic rxUseCoreClk;
        logic rxCoreClk;
        logic txUseCoreClk;
        logic txCoreClk;
    } tpcf_ctl_t;

    localparam tpcf_ctl_t CTL_RESET = 7'h00;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } tpcf_word_t;

    localparam tpcf_word_t WORD_RESET = 17'h0_0000;

endpackage

// [logic/tpcf_fifo.sv]
// phase compensation fifo with sticky overflow and underrun flag
`timescale 1ns/1ns
`default_nettype none

module tpcf_fifo (
    input wire logic clk,
    input wire logic rstN,
    input wire logic clear,
    input wire logic wrEn,
    input wire logic [tpcf_pkg::DATA_W-1:0] wrData,
    input wire logic rdEn,
    output var tpcf_pkg::tpcf_word_t rdWord,
    output logic full,
    output logic error
);

    typedef struct packed {
        logic [tpcf_pkg::FIFO_DEPTH-1:0][tpcf_pkg::DATA_W-1:0] mem;
        logic [tpcf_pkg::PTR_W-1:0] wrPtr;
        logic [tpcf_pkg::PTR_W-1:0] rdPtr;
        logic primed;
        tpcf_pkg::tpcf_word_t rdWord;
        logic error;
    } tpcf_fifo_state_t;

    tpcf_fifo_state_t q;
    tpcf_fifo_state_t d;
    logic [tpcf_pkg::PTR_W-1:0] level;
    logic empty;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        level = q.wrPtr - q.rdPtr;
        empty = (level == '0);
        full = (level == tpcf_pkg::FIFO_FULL_LEVEL);
        d = q;
        d.rdWord.valid = 1'b0;
        if (clear) begin
            d = '0;
        end else begin
            // no rate matching: equal read and write rates assumed
            if (wrEn) begin
                if (full) begin
                    d.error = 1'b1;
                end else begin
                    d.mem[q.wrPtr[tpcf_pkg::ADDR_W-1:0]] = wrData;
                    d.wrPtr = q.wrPtr + 3'h1;
                end
            end
            if (!q.primed && level >= tpcf_pkg::FIFO_PRIME_LEVEL) begin
                d.primed = 1'b1;
            end
            if (rdEn && q.primed) begin
                if (empty) begin
                    d.error = 1'b1;
                end else begin
                    d.rdWord.valid = 1'b1;
                    d.rdWord.data = q.mem[q.rdPtr[tpcf_pkg::ADDR_W-1:0]];
                    d.rdPtr = q.rdPtr + 3'h1;
                end
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdWord = q.rdWord;
    assign error = q.error;

endmodule

`default_nettype wire

// [logic/tpcf_ports.sv]
// core facing ports of a transceiver channel: tx and rx phase compensation fifos
// Summary of operation
// - rx digital reset clears the receive pcs logic and its fifo path
// - tx digital reset clears the transmit pcs logic, independent of rx
// - rx fifo raises an error output on overflow or underrun
// - tx fifo raises an error output on overflow or underrun
// - with rx core clock selected, rx fifo reads on that clock
// - with tx core clock selected, tx fifo writes on that clock
// - no receive signal-detect output exists in this configuration
// - power down clears both fifos and stops the parallel clock; the control synchroniser and core clock edge detection keep running
`timescale 1ns/1ns
`default_nettype none

module tpcf_ports (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic powerDown,
    input wire logic rxDigitalReset,
    input wire logic txDigitalReset,
    input wire logic rxUseCoreClk,
    input wire logic rxCoreClk,
    input wire logic txUseCoreClk,
    input wire logic txCoreClk,
    input wire logic [tpcf_pkg::DATA_W-1:0] txCoreData,
    input wire logic txCoreValid,
    output logic txCoreReady,
    output logic [tpcf_pkg::DATA_W-1:0] txPcsData,
    output logic txPcsValid,
    input wire logic [tpcf_pkg::DATA_W-1:0] rxPcsData,
    input wire logic rxPcsValid,
    output logic [tpcf_pkg::DATA_W-1:0] rxCoreData,
    output logic rxCoreValid,
    output logic parClkOut,
    output logic rxFifoError,
    output logic txFifoError
);

    typedef struct packed {
        logic [1:0] rstPipe;
        // three-flop pin synchroniser and its filtered result
        tpcf_pkg::tpcf_ctl_t s1;
        tpcf_pkg::tpcf_ctl_t s2;
        tpcf_pkg::tpcf_ctl_t s3;
        tpcf_pkg::tpcf_ctl_t ctl;
        logic settled;
        logic rxCoreClkPrev;
        logic txCoreClkPrev;
        // parallel clock divider
        logic [1:0] divCnt;
        logic parClk;
    } tpcf_top_state_t;

    tpcf_top_state_t q;
    tpcf_top_state_t d;
    tpcf_pkg::tpcf_ctl_t ctlIn;
    tpcf_pkg::tpcf_word_t txWord;
    tpcf_pkg::tpcf_word_t rxWord;
    logic rstSync;
    logic parTick;
    logic rxCoreEdge;
    logic txCoreEdge;
    logic rxClear;
    logic txClear;
    logic rxRdTick;
    logic txWrTick;
    logic txFull;

    // ************************************************************
    // pin sampling
    // ************************************************************
    always_comb begin
        ctlIn.rxDigitalReset = rxDigitalReset;
        ctlIn.txDigitalReset = txDigitalReset;
        ctlIn.powerDown = powerDown;
        ctlIn.rxUseCoreClk = rxUseCoreClk;
        ctlIn.rxCoreClk = rxCoreClk;
        ctlIn.txUseCoreClk = txUseCoreClk;
        ctlIn.txCoreClk = txCoreClk;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = q;
        // two-flop release of the reset copy
        d.rstPipe = {q.rstPipe[0], 1'b1};
        d.s1 = ctlIn;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // a change counts once the second and third stage agree
        d.ctl = (q.s2 & ~(q.s2 ^ q.s3)) | (q.ctl & (q.s2 ^ q.s3));
        // the filtered word is trusted once the second and third stages first agree
        if (q.s2 == q.s3) begin
            d.settled = 1'b1;
        end
        // last synchronised core clock levels, for edge detection
        d.rxCoreClkPrev = q.ctl.rxCoreClk;
        d.txCoreClkPrev = q.ctl.txCoreClk;
        // parallel clock divider, stopped while powered down
        if (q.ctl.powerDown) begin
            d.divCnt = 2'h0;
            d.parClk = 1'b0;
        end else if (q.divCnt == tpcf_pkg::PAR_HALF_LAST) begin
            d.divCnt = 2'h0;
            d.parClk = ~q.parClk;
        end else begin
            d.divCnt = q.divCnt + 2'h1;
        end
        // hold the filtered controls, edge history and divider idle until the reset copy is released; the synchroniser keeps sampling
        if (!q.rstPipe[1]) begin
            d.ctl = tpcf_pkg::CTL_RESET;
            d.settled = 1'b0;
            d.rxCoreClkPrev = 1'b0;
            d.txCoreClkPrev = 1'b0;
            d.divCnt = 2'h0;
            d.parClk = 1'b0;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q.rstPipe <= tpcf_pkg::RST_PIPE_RESET;
            q.s1 <= tpcf_pkg::CTL_RESET;
            q.s2 <= tpcf_pkg::CTL_RESET;
            q.s3 <= tpcf_pkg::CTL_RESET;
            q.ctl <= tpcf_pkg::CTL_RESET;
            q.settled <= 1'b0;
            q.rxCoreClkPrev <= 1'b0;
            q.txCoreClkPrev <= 1'b0;
            q.divCnt <= 2'h0;
            q.parClk <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // local resets
    // ************************************************************
    always_comb begin
        rstSync = q.rstPipe[1];
        // fifos stay cleared until the synchronised controls are trusted
        rxClear = !rstSync || !q.settled || q.ctl.powerDown || q.ctl.rxDigitalReset;
        txClear = !rstSync || !q.settled || q.ctl.powerDown || q.ctl.txDigitalReset;
    end

    // ************************************************************
    // clock selection: core clock edges or the parallel tick
    // ************************************************************
    always_comb begin
        // parallel tick: parClkOut low and about to rise
        parTick = !q.ctl.powerDown && !q.parClk && (q.divCnt == tpcf_pkg::PAR_HALF_LAST);
        // core strobes: rising edges of the synchronised core clocks
        rxCoreEdge = q.ctl.rxCoreClk && !q.rxCoreClkPrev;
        txCoreEdge = q.ctl.txCoreClk && !q.txCoreClkPrev;
        if (q.ctl.rxUseCoreClk) begin
            rxRdTick = rxCoreEdge;
        end else begin
            rxRdTick = parTick;
        end
        if (q.ctl.txUseCoreClk) begin
            txWrTick = txCoreEdge;
        end else begin
            txWrTick = parTick;
        end
    end

    // ************************************************************
    // transmit fifo: core writes, pcs reads on the parallel clock
    // ************************************************************
    tpcf_fifo txFifo (
        .clk(sys_clk),
        .rstN(rst_n),
        .clear(txClear),
        .wrEn(txWrTick && txCoreValid),
        .wrData(txCoreData),
        .rdEn(parTick),
        .rdWord(txWord),
        .full(txFull),
        .error(txFifoError)
    );

    // ************************************************************
    // receive fifo: pcs writes on the parallel clock, core reads
    // ************************************************************
    tpcf_fifo rxFifo (
        .clk(sys_clk),
        .rstN(rst_n),
        .clear(rxClear),
        .wrEn(parTick && rxPcsValid),
        .wrData(rxPcsData),
        .rdEn(rxRdTick),
        .rdWord(rxWord),
        .full(),
        .error(rxFifoError)
    );

    // ************************************************************
    // transmit outputs
    // ************************************************************
    // ready falls while the fifo is full or held in reset
    assign txCoreReady = !txClear && !txFull;
    assign txPcsData = txWord.data;
    assign txPcsValid = txWord.valid;
    assign parClkOut = q.parClk;

    // ************************************************************
    // receive outputs; the receive side offers no signal-detect output
    // ************************************************************
    assign rxCoreData = rxWord.data;
    assign rxCoreValid = rxWord.valid;

endmodule

`default_nettype wire

// [tb/tpcf_ports_props.sv]
// concurrent checks on the ports of the phase compensation fifo block
`timescale 1ns/1ns
`default_nettype none

module tpcf_ports_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic powerDown,
    input wire logic rxDigitalReset,
    input wire logic txDigitalReset,
    input wire logic rxUseCoreClk,
    input wire logic txCoreReady,
    input wire logic txPcsValid,
    input wire logic rxCoreValid,
    input wire logic parClkOut,
    input wire logic rxFifoError,
    input wire logic txFifoError
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // *****
    // sequences
    // *****
    sequence s_rxQuiet; (!rxDigitalReset && !powerDown)[*6]; endsequence
    sequence s_txQuiet; (!txDigitalReset && !powerDown)[*6]; endsequence
    sequence s_parRise; !powerDown[*6] ##0 $rose(parClkOut); endsequence
    sequence s_rxParSel; !rxUseCoreClk[*6]; endsequence

    // *****
    // properties
    // *****
    property p_rxRst; rxDigitalReset[*6] |-> !rxFifoError && !rxCoreValid; endproperty
    a_rxRst: assert property (p_rxRst) else $error("rx reset");
    property p_txRst; txDigitalReset[*6] |-> !txFifoError && !txPcsValid && !txCoreReady; endproperty
    a_txRst: assert property (p_txRst) else $error("tx reset");
    property p_rxErr; s_rxQuiet ##0 rxFifoError |=> rxFifoError; endproperty
    a_rxErr: assert property (p_rxErr) else $error("rx error dropped");
    property p_txErr; s_txQuiet ##0 txFifoError |=> txFifoError; endproperty
    a_txErr: assert property (p_txErr) else $error("tx error dropped");
    property p_pd; powerDown[*6] |-> !parClkOut && !txPcsValid && !rxCoreValid && !txCoreReady; endproperty
    a_pd: assert property (p_pd) else $error("power down");
    property p_par; s_parRise |-> ##1 parClkOut ##1 !parClkOut ##1 !parClkOut ##1 parClkOut; endproperty
    a_par: assert property (p_par) else $error("parallel clock");
    property p_txVal; txPcsValid |-> $rose(parClkOut) ##1 !txPcsValid; endproperty
    a_txVal: assert property (p_txVal) else $error("tx read tick");
    property p_rxPar; s_rxParSel ##0 rxCoreValid |-> $rose(parClkOut); endproperty
    a_rxPar: assert property (p_rxPar) else $error("rx read tick");
endmodule

`default_nettype wire

// [tb/tpcf_core_model.sv]
// core clock source of the user logic model
`timescale 1ns/1ns
`default_nettype none

module tpcf_core_model (
    input wire logic sys_clk,
    input wire logic run,
    output logic coreClk = 1'b0
);
    logic [1:0] phaseQ = 2'h0;

    // same rate as the parallel clock, still while idle; never looks at the error flags
    always @(negedge sys_clk) begin
        if (!run) begin
            phaseQ <= 2'h0;
            coreClk <= 1'b0;
        end else begin
            phaseQ <= phaseQ + 2'h1;
            coreClk <= phaseQ[1];
        end
    end
endmodule

`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the phase compensation fifo ports
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic powerDown = 1'b0;
    logic rxDigitalReset = 1'b1;
    logic txDigitalReset = 1'b1;
    logic rxUseCoreClk = 1'b0;
    logic txUseCoreClk = 1'b0;
    logic rxRun = 1'b0;
    logic txRun = 1'b0;
    logic txCoreValid = 1'b0;
    logic rxPcsValid = 1'b0;
    logic [15:0] txCoreData = 16'h0000;
    logic [15:0] rxPcsData = 16'h0000;
    logic rxCoreClk, txCoreClk, txCoreReady, txPcsValid, rxCoreValid, parClkOut, rxFifoError, txFifoError;
    logic [15:0] txPcsData, rxCoreData;
    int fails = 0;
    int nChecks = 0;

    always #50 sys_clk = ~sys_clk;

    tpcf_ports uut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .powerDown(powerDown),
        .rxDigitalReset(rxDigitalReset),
        .txDigitalReset(txDigitalReset),
        .rxUseCoreClk(rxUseCoreClk),
        .rxCoreClk(rxCoreClk),
        .txUseCoreClk(txUseCoreClk),
        .txCoreClk(txCoreClk),
        .txCoreData(txCoreData),
        .txCoreValid(txCoreValid),
        .txCoreReady(txCoreReady),
        .txPcsData(txPcsData),
        .txPcsValid(txPcsValid),
        .rxPcsData(rxPcsData),
        .rxPcsValid(rxPcsValid),
        .rxCoreData(rxCoreData),
        .rxCoreValid(rxCoreValid),
        .parClkOut(parClkOut),
        .rxFifoError(rxFifoError),
        .txFifoError(txFifoError)
    );
    tpcf_core_model uTx (.sys_clk(sys_clk), .run(txRun), .coreClk(txCoreClk));
    tpcf_core_model uRx (.sys_clk(sys_clk), .run(rxRun), .coreClk(rxCoreClk));

    // *****
    // helpers
    // *****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        nChecks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task results;
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic txGo(input logic c, input logic [15:0] d);
        txUseCoreClk = c;
        txRun <= c;
        txCoreData = d;
        txCoreValid = 1'b1;
        for (int i = 0; i < 80 && txPcsValid !== 1'b1; i++) @(negedge sys_clk);
        chk(txPcsData, d, "tx data");
        chk(16'(txFifoError), 16'h0000, "tx error at equal rates");
        // parallel mode starves through valid, core clock mode through a stopped core clock
        txCoreValid = c;
        txRun <= 1'b0;
        for (int i = 0; i < 60 && txFifoError !== 1'b1; i++) @(negedge sys_clk);
        chk(16'(txFifoError), 16'h0001, "tx underrun");
        txCoreValid = 1'b0;
        txDigitalReset = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(16'(txFifoError), 16'h0000, "tx reset");
        txDigitalReset = 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic rxGo(input logic c, input logic [15:0] d);
        rxUseCoreClk = c;
        rxRun <= c;
        rxPcsData = d;
        rxPcsValid = 1'b1;
        for (int i = 0; i < 80 && rxCoreValid !== 1'b1; i++) @(negedge sys_clk);
        chk(rxCoreData, d, "rx data");
        chk(16'(rxFifoError), 16'h0000, "rx error at equal rates");
        rxRun <= 1'b0;
        rxPcsValid = c;
        for (int i = 0; i < 60 && rxFifoError !== 1'b1; i++) @(negedge sys_clk);
        chk(16'(rxFifoError), 16'h0001, "rx overflow or underrun");
        rxPcsValid = 1'b0;
        rxDigitalReset = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(16'(rxFifoError), 16'h0000, "rx reset");
        chk(16'(txCoreReady), 16'h0001, "tx side during rx reset");
        rxDigitalReset = 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask

    // *****
    // scenarios
    // *****
    task tTxPar;
        txGo(1'b0, 16'ha5c3);
        $display("test tx parallel done");
    endtask

    task tTxCore;
        txGo(1'b1, 16'h5a3c);
        $display("test tx core clock done");
    endtask

    task tRxPar;
        rxGo(1'b0, 16'h3c96);
        $display("test rx parallel done");
    endtask

    task tRxCore;
        rxGo(1'b1, 16'hc369);
        $display("test rx core clock done");
    endtask

    task tPowerDown;
        txCoreValid = 1'b1;
        powerDown = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(16'(parClkOut), 16'h0000, "clock out in power down");
        chk(16'(txCoreReady), 16'h0000, "ready in power down");
        powerDown = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk(16'(txCoreReady), 16'h0001, "ready after power down");
        txCoreValid = 1'b0;
        $display("test power down done");
    endtask

    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        rxDigitalReset = 1'b0;
        txDigitalReset = 1'b0;
        repeat (8) @(negedge sys_clk);
        tTxPar();
        tTxCore();
        tRxPar();
        tRxCore();
        tPowerDown();
        results();
    end

    initial begin
        #400000;
        fails++;
        results();
    end
endmodule

bind tpcf_ports tpcf_ports_props uProps (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .powerDown(powerDown),
    .rxDigitalReset(rxDigitalReset),
    .txDigitalReset(txDigitalReset),
    .rxUseCoreClk(rxUseCoreClk),
    .txCoreReady(txCoreReady),
    .txPcsValid(txPcsValid),
    .rxCoreValid(rxCoreValid),
    .parClkOut(parClkOut),
    .rxFifoError(rxFifoError),
    .txFifoError(txFifoError)
);

`default_nettype wire
